// ---- hdl/ddrp_consts.svh ----
`ifndef DDRP_CONSTS_SVH
`define DDRP_CONSTS_SVH
// Organisation and bank layout
`define DDRP_LANES      36
`define DDRP_BANK_W     3
`define DDRP_ADDR_W     4
`define DDRP_BURST      2
// Depth of the gap-free read stream buffer
`define DDRP_FIFO_DEPTH 8
// Reset values of the pin-side flops
`define DDRP_STROBE_RST 1'b0
`define DDRP_OE_N_RST   1'b1
`endif

// ---- hdl/ddrp_pkg.sv ----
package ddrp_pkg;
  // Link-side sequencer states, one-hot
  typedef enum logic [3:0]
  {
    ST_IDLE   = 4'h1,
    ST_WRISE  = 4'h2,
    ST_WSTORE = 4'h4,
    ST_RBEAT1 = 4'h8
  } ddrp_state_t;
endpackage

// ---- hdl/ddrp_port.sv ----
`timescale 1ns/100ps
`include "ddrp_consts.svh"

// Dual-clock buffer with gray-coded pointers
module ddrp_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = `DDRP_FIFO_DEPTH
) (
  input  wire logic             wr_clock,
  input  wire logic             wr_rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             rd_clock,
  input  wire logic             rd_rst_n,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] sync1;
    logic [AW:0] sync2;
  } ddrp_ptr_t;

  generate
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("ddrp_fifo: DEPTH must be a power of two, 4 or more");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  ddrp_ptr_t        wp_r;
  ddrp_ptr_t        wp_nxt;
  ddrp_ptr_t        rp_r;
  ddrp_ptr_t        rp_nxt;
  logic             push;
  logic             pop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Full compares against the read pointer seen through two flops
  assign in_ready  = wp_r.gray !=
                     {~wp_r.sync2[AW:AW-1], wp_r.sync2[AW-2:0]};
  assign out_valid = rp_r.gray != rp_r.sync2;
  assign out_data  = mem[rp_r.bin[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Write side next state
  always_comb
  begin
    wp_nxt       = wp_r;
    wp_nxt.sync1 = rp_r.gray;
    wp_nxt.sync2 = wp_r.sync1;
    if (push)
    begin
      wp_nxt.bin  = wp_r.bin + 1'b1;
      wp_nxt.gray = to_gray(wp_nxt.bin);
    end
    if (!wr_rst_n)
      wp_nxt = '0;
  end

  always_ff @(posedge wr_clock)
  begin
    wp_r <= wp_nxt;
    if (push)
      mem[wp_r.bin[AW-1:0]] <= in_data;
  end

  // Read side next state
  always_comb
  begin
    rp_nxt       = rp_r;
    rp_nxt.sync1 = wp_r.gray;
    rp_nxt.sync2 = rp_r.sync1;
    if (pop)
    begin
      rp_nxt.bin  = rp_r.bin + 1'b1;
      rp_nxt.gray = to_gray(rp_nxt.bin);
    end
    if (!rd_rst_n)
      rp_nxt = '0;
  end

  always_ff @(posedge rd_clock)
    rp_r <= rp_nxt;
endmodule

// Data port: bank memory, DDR capture and launch, read stream
module ddrp_port #(
  parameter int W  = `DDRP_LANES,
  parameter int AW = `DDRP_ADDR_W
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    link_clock,
  input  wire logic                    chip_select_n,
  input  wire logic                    cmd_write_n,
  input  wire logic                    cmd_refresh_n,
  input  wire logic [`DDRP_BANK_W-1:0] bank_select,
  input  wire logic [AW-1:0]           address,
  input  wire logic [W-1:0]            data_lanes_in,
  output logic [W-1:0]                 data_lanes_out,
  output logic                         data_lanes_oe_n,
  input  wire logic                    write_mask,
  output logic [1:0]                   read_data_strobe_pair_p,
  output logic [1:0]                   read_data_strobe_pair_n,
  output logic                         read_valid,
  output logic                         beat_valid,
  output logic [2*W-1:0]               beat_data,
  input  wire logic                    beat_ready
);
  localparam int BW   = `DDRP_BANK_W;
  localparam int MIDX = BW + AW + 1;
  localparam int WORDS = `DDRP_BURST << (BW + AW);

  typedef struct packed {
    ddrp_pkg::ddrp_state_t state;
    logic [BW-1:0]         bank;
    logic [AW-1:0]         addr;
    logic [W-1:0]          rise_data;
    logic                  rise_mask;
    logic [W-1:0]          out_data;
    logic                  oe_n;
    logic                  valid;
    logic [1:0]            strb_p;
    logic [1:0]            strb_n;
    logic                  push;
    logic [2*W-1:0]        push_data;
  } ddrp_link_t;

  typedef struct packed {
    logic           valid;
    logic [2*W-1:0] data;
  } ddrp_core_t;

  generate
    if (!(W == 36 || W == 18 || W == 9))
    begin : g_bad_width
      $error("ddrp_port: W must be 9, 18 or 36");
    end
  endgenerate

  logic [W-1:0] mem [WORDS];
  ddrp_link_t   lk_r;
  ddrp_link_t   lk_nxt;
  ddrp_core_t   co_r;
  ddrp_core_t   co_nxt;
  logic [1:0]   lrst_r;
  logic [W:0]   fall_r;
  logic         link_rst_n;
  logic         cmd_ok;
  logic         cmd_wr;
  logic         cmd_rd;
  logic         fifo_ready;
  logic         fifo_valid;
  logic [2*W-1:0] fifo_data;
  logic         pop;

  // Strobe pair that serves a lane; narrowest part uses pair 0 only
  function automatic int lane_pair(input int lane);
    return (W == 9) ? 0 : ((lane >= W / 2) ? 1 : 0);
  endfunction

  function automatic logic pair_used(input int p);
    return lane_pair(W - 1) >= p;
  endfunction

  // Flat memory index from bank, address and beat
  function automatic logic [MIDX-1:0] mem_idx(
    input logic [BW-1:0] b,
    input logic [AW-1:0] a,
    input logic          beat
  );
    return {b, a, beat};
  endfunction

  assign link_rst_n = lrst_r[1];
  assign cmd_ok = (lk_r.state == ddrp_pkg::ST_IDLE) && !chip_select_n;
  assign cmd_wr = cmd_ok && !cmd_write_n;
  assign cmd_rd = cmd_ok && cmd_write_n && cmd_refresh_n;

  // Reset reaches the link domain through two flops
  always_ff @(posedge link_clock)
    lrst_r <= {lrst_r[0], rst_n};

  // Falling-edge beat with its mask; write strobes share link_clock
  always_ff @(negedge link_clock)
    fall_r <= {write_mask, data_lanes_in};

  // Link sequencer; commands only taken when idle and selected
  always_comb
  begin
    lk_nxt       = lk_r;
    lk_nxt.valid = 1'b0;
    lk_nxt.oe_n  = `DDRP_OE_N_RST;
    lk_nxt.push  = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      lk_nxt.strb_p[p] = pair_used(p) && !lk_r.strb_p[p];
      lk_nxt.strb_n[p] = pair_used(p) && !lk_nxt.strb_p[p];
    end
    case (lk_r.state)
      ddrp_pkg::ST_IDLE:
      begin
        if (cmd_wr || (cmd_rd && fifo_ready))
        begin
          lk_nxt.bank = bank_select;
          lk_nxt.addr = address;
        end
        if (cmd_wr)
          lk_nxt.state = ddrp_pkg::ST_WRISE;
        else if (cmd_rd && fifo_ready)
        begin
          // Read refused while the stream buffer is full
          lk_nxt.out_data = mem[mem_idx(bank_select, address, 1'b0)];
          lk_nxt.valid = 1'b1;
          lk_nxt.oe_n  = 1'b0;
          lk_nxt.push  = 1'b1;
          lk_nxt.push_data =
            {mem[mem_idx(bank_select, address, 1'b1)],
             mem[mem_idx(bank_select, address, 1'b0)]};
          lk_nxt.state = ddrp_pkg::ST_RBEAT1;
        end
      end
      ddrp_pkg::ST_WRISE:
      begin
        lk_nxt.rise_data = data_lanes_in;
        lk_nxt.rise_mask = write_mask;
        lk_nxt.state     = ddrp_pkg::ST_WSTORE;
      end
      ddrp_pkg::ST_WSTORE:
        lk_nxt.state = ddrp_pkg::ST_IDLE;
      ddrp_pkg::ST_RBEAT1:
      begin
        lk_nxt.out_data = mem[mem_idx(lk_r.bank, lk_r.addr, 1'b1)];
        lk_nxt.valid = 1'b1;
        lk_nxt.oe_n  = 1'b0;
        lk_nxt.state = ddrp_pkg::ST_IDLE;
      end
      default:
        lk_nxt.state = ddrp_pkg::ST_IDLE;
    endcase
    if (!link_rst_n)
    begin
      lk_nxt        = '0;
      lk_nxt.state  = ddrp_pkg::ST_IDLE;
      lk_nxt.oe_n   = `DDRP_OE_N_RST;
      lk_nxt.strb_p = {2{`DDRP_STROBE_RST}};
      lk_nxt.strb_n = {2{`DDRP_STROBE_RST}};
    end
  end

  // Both beats land together; a high mask keeps the old word
  always_ff @(posedge link_clock)
  begin
    lk_r <= lk_nxt;
    if (lk_r.state == ddrp_pkg::ST_WSTORE)
    begin
      if (!lk_r.rise_mask)
        mem[mem_idx(lk_r.bank, lk_r.addr, 1'b0)] <= lk_r.rise_data;
      if (!fall_r[W])
        mem[mem_idx(lk_r.bank, lk_r.addr, 1'b1)] <= fall_r[W-1:0];
    end
  end

  assign data_lanes_out          = lk_r.out_data;
  assign data_lanes_oe_n         = lk_r.oe_n;
  assign read_valid              = lk_r.valid;
  assign read_data_strobe_pair_p = lk_r.strb_p;
  assign read_data_strobe_pair_n = lk_r.strb_n;

  ddrp_fifo #(
    .WIDTH (2 * W),
    .DEPTH (`DDRP_FIFO_DEPTH)
  ) u_fifo (
    .wr_clock  (link_clock),
    .wr_rst_n  (link_rst_n),
    .in_valid  (lk_r.push),
    .in_ready  (fifo_ready),
    .in_data   (lk_r.push_data),
    .rd_clock  (clock),
    .rd_rst_n  (rst_n),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // Output stage keeps the core-side outputs on flops
  assign pop = fifo_valid && (!co_r.valid || beat_ready);

  always_comb
  begin
    co_nxt = co_r;
    if (pop)
    begin
      co_nxt.valid = 1'b1;
      co_nxt.data  = fifo_data;
    end
    else if (beat_ready)
      co_nxt.valid = 1'b0;
    if (!rst_n)
      co_nxt = '0;
  end

  always_ff @(posedge clock)
    co_r <= co_nxt;

  assign beat_valid = co_r.valid;
  assign beat_data  = co_r.data;

  // Checks on the link-side behaviour
  a_strobe_toggle: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    $past(link_rst_n) |->
      read_data_strobe_pair_p[0] != $past(read_data_strobe_pair_p[0]))
    else $error("read strobe stopped toggling");

  a_strobe_opposite: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    $past(link_rst_n) |->
      read_data_strobe_pair_p[0] != read_data_strobe_pair_n[0])
    else $error("read strobe legs not opposite");

  generate
    if (W == 9)
    begin : g_x9
      a_pair_unused: assert property (
        @(posedge link_clock) disable iff (!link_rst_n)
        !read_data_strobe_pair_p[1] && !read_data_strobe_pair_n[1])
        else $error("unused strobe pair moved");
    end
  endgenerate

  a_read_burst: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    (cmd_rd && fifo_ready) |=>
      (read_valid && !data_lanes_oe_n) [*2] ##1 !read_valid)
    else $error("read burst not two beats");

  a_valid_drive: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    read_valid == !data_lanes_oe_n)
    else $error("read valid not matching drive");

  a_write_quiet: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    cmd_wr |=> !read_valid [*2])
    else $error("read valid during write");

  a_cs_ignore: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    (lk_r.state == ddrp_pkg::ST_IDLE && chip_select_n) |=>
      lk_r.state == ddrp_pkg::ST_IDLE && !read_valid)
    else $error("command taken while deselected");

  a_bank_capture: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    cmd_wr |=> lk_r.bank == $past(bank_select) ##1
      lk_r.state == ddrp_pkg::ST_WSTORE)
    else $error("bank not captured with command");

  a_mask_keep: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    (lk_r.state == ddrp_pkg::ST_WSTORE && lk_r.rise_mask) |=>
      mem[mem_idx(lk_r.bank, lk_r.addr, 1'b0)] ==
      $past(mem[mem_idx(lk_r.bank, lk_r.addr, 1'b0)]))
    else $error("masked beat was stored");

  a_beat_store: assert property (
    @(posedge link_clock) disable iff (!link_rst_n)
    (lk_r.state == ddrp_pkg::ST_WSTORE && !fall_r[W]) |=>
      mem[mem_idx(lk_r.bank, lk_r.addr, 1'b1)] == $past(fall_r[W-1:0]))
    else $error("falling beat not stored");

  c_write: cover property (
    @(posedge link_clock) disable iff (!link_rst_n) cmd_wr);
  c_read: cover property (
    @(posedge link_clock) disable iff (!link_rst_n)
    cmd_rd && fifo_ready);
  c_masked: cover property (
    @(posedge link_clock) disable iff (!link_rst_n)
    lk_r.state == ddrp_pkg::ST_WSTORE && lk_r.rise_mask);
  c_stalled: cover property (
    @(posedge link_clock) disable iff (!link_rst_n)
    cmd_rd && !fifo_ready);
endmodule

// ---- tb/ddrp_ctrl_model.sv ----
`timescale 1ns/100ps

// Host controller: commands at the falling link edge, beats around both
module ddrp_ctrl_model (
  input  wire logic        link_clock,
  input  wire logic [35:0] data_lanes_out,
  input  wire logic        data_lanes_oe_n,
  input  wire logic        read_valid,
  output logic             chip_select_n,
  output logic             cmd_write_n,
  output logic             cmd_refresh_n,
  output logic [2:0]       bank_select,
  output logic [3:0]       address,
  output logic [35:0]      data_lanes_in,
  output logic             write_mask
);
  // Deselected at start, mask low because masking is opt-in
  initial
  begin
    chip_select_n = 1'b1;
    cmd_write_n = 1'b1;
    cmd_refresh_n = 1'b1;
    bank_select = 3'h0;
    address = 4'h0;
    data_lanes_in = 36'h0;
    write_mask = 1'b0;
  end

  // One command; reads span two link cycles, all others two plus 3 ns
  task automatic issue(input logic cs_n, we_n, ref_n, input logic [2:0] b,
    input logic [3:0] a, input logic [35:0] d0, d1, input logic m0, m1,
    output logic acc, output logic [35:0] q0, q1);
    @(negedge link_clock);
    chip_select_n = cs_n;
    cmd_write_n = we_n;
    cmd_refresh_n = ref_n;
    bank_select = b;
    address = a;
    @(negedge link_clock);
    chip_select_n = 1'b1;
    q0 = data_lanes_out;
    q1 = q0;
    if (we_n && ref_n)
    begin
      acc = read_valid & ~data_lanes_oe_n;
      // Second beat read mid-cycle, where it has settled
      @(negedge link_clock);
      q1 = data_lanes_out;
    end
    else
    begin
      data_lanes_in = d0;
      write_mask = m0;
      @(posedge link_clock);
      #3;
      data_lanes_in = d1;
      write_mask = m1;
      acc = read_valid | ~data_lanes_oe_n;
      @(negedge link_clock);
      #3;
      // Released lanes flip so a stale copy can never pass for data
      data_lanes_in = ~d1;
      write_mask = 1'b0;
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_top;
  logic        clock, rst_n, link_clock, beat_ready, hold_ready, strobe_on;
  logic        ready_nxt;
  logic        chip_select_n, cmd_write_n, cmd_refresh_n, write_mask;
  logic        data_lanes_oe_n, read_valid, beat_valid;
  logic [2:0]  bank_select;
  logic [3:0]  address;
  logic [35:0] data_lanes_in, data_lanes_out;
  logic [1:0]  strobe_p, strobe_n, last_p;
  logic [71:0] beat_data, exp_w;
  logic [35:0] mem [0:255];
  logic [71:0] exp_q [$];
  logic [31:0] seed;
  int          mismatches, n_tests, cycles, n_acc;

  // Clocks of unrelated phase
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    link_clock = 1'b0;
    #3.3;
    forever #7.5 link_clock = ~link_clock;
  end

  ddrp_port dut (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
    .chip_select_n(chip_select_n), .cmd_write_n(cmd_write_n),
    .cmd_refresh_n(cmd_refresh_n), .bank_select(bank_select),
    .address(address), .data_lanes_in(data_lanes_in),
    .data_lanes_out(data_lanes_out), .data_lanes_oe_n(data_lanes_oe_n),
    .write_mask(write_mask), .read_data_strobe_pair_p(strobe_p),
    .read_data_strobe_pair_n(strobe_n), .read_valid(read_valid),
    .beat_valid(beat_valid), .beat_data(beat_data), .beat_ready(beat_ready));

  ddrp_ctrl_model u_ctrl (.link_clock(link_clock),
    .data_lanes_out(data_lanes_out), .data_lanes_oe_n(data_lanes_oe_n),
    .read_valid(read_valid), .chip_select_n(chip_select_n),
    .cmd_write_n(cmd_write_n), .cmd_refresh_n(cmd_refresh_n),
    .bank_select(bank_select), .address(address),
    .data_lanes_in(data_lanes_in), .write_mask(write_mask));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [35:0] rnd36();
    return 36'({xs(), xs()});
  endfunction

  task automatic conclude();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Write or refresh; the model memory keeps a masked beat's old word
  task automatic wr(input logic cs_n, refr, input logic [2:0] b,
    input logic [3:0] a, input logic [35:0] d0, d1, input logic m0, m1);
    logic        acc;
    logic [35:0] q0, q1;
    u_ctrl.issue(cs_n, refr, ~refr, b, a, d0, d1, m0, m1, acc, q0, q1);
    `CHK("idle read_valid", 1'b0, acc)
    if (!cs_n && !refr)
    begin
      if (!m0) mem[{b, a, 1'b0}] = d0;
      if (!m1) mem[{b, a, 1'b1}] = d1;
    end
  endtask

  task automatic rd(input logic [2:0] b, input logic [3:0] a,
    input logic may_drop);
    logic        acc;
    logic [35:0] q0, q1;
    u_ctrl.issue(1'b0, 1'b1, 1'b1, b, a, 36'h0, 36'h0, 1'b0, 1'b0,
      acc, q0, q1);
    if (!may_drop) `CHK("read taken", 1'b1, acc)
    if (acc === 1'b1)
    begin
      `CHK("beat0", mem[{b, a, 1'b0}], q0)
      `CHK("beat1", mem[{b, a, 1'b1}], q1)
      exp_q.push_back({mem[{b, a, 1'b1}], mem[{b, a, 1'b0}]});
      n_acc++;
    end
  endtask

  // Stream side: random stalls; the word taken at the next rising edge
  // is checked here, mid-cycle, where the outputs have settled
  always @(negedge clock)
  begin
    ready_nxt = !hold_ready && (xs() % 4) != 0;
    if (beat_valid === 1'b1 && ready_nxt)
    begin
      exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      `CHK("beat_data", exp_w, beat_data)
    end
    beat_ready <= ready_nxt;
  end

  // Run limit
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  // Strobes sampled mid-cycle: opposite pair, toggled since last cycle
  always @(negedge link_clock)
  begin
    if (strobe_on)
    begin
      `CHK("strobe_n", ~strobe_p, strobe_n)
      `CHK("strobe toggle", ~last_p, strobe_p)
      `CHK("strobe pairs", {2{strobe_p[0]}}, strobe_p)
    end
    last_p = strobe_p;
  end

  initial
  begin
    logic [31:0] k;
    seed = 32'h834EFE3D;
    rst_n = 1'b0;
    hold_ready = 1'b0;
    beat_ready = 1'b0;
    strobe_on = 1'b0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge link_clock);
    strobe_on = 1'b1;
    // Distinct data in every bank and word
    for (int i = 0; i < 128; i++)
      wr(1'b0, 1'b0, i[6:4], i[3:0], rnd36(), rnd36(), 1'b0, 1'b0);
    // Masked beats, deselected writes, refreshes and reads mixed
    for (int i = 0; i < 80; i++)
    begin
      k = xs();
      case (k[1:0])
        2'h0: wr(1'b0, 1'b0, k[4:2], k[8:5], rnd36(), rnd36(), k[9], k[10]);
        2'h1: wr(1'b1, 1'b0, k[4:2], k[8:5], rnd36(), rnd36(), 1'b0, 1'b0);
        2'h2: wr(1'b0, 1'b1, k[4:2], k[8:5], rnd36(), rnd36(), 1'b0, 1'b0);
        default: rd(k[4:2], k[8:5], 1'b0);
      endcase
    end
    // Back-to-back reads of the whole array
    for (int i = 0; i < 128; i++)
      rd(i[6:4], i[3:0], 1'b0);
    for (int t = 0; t < 300 && exp_q.size() > 0; t++) @(posedge clock);
    // Stalled stream: the buffer fills and further reads are refused
    hold_ready = 1'b1;
    n_acc = 0;
    for (int i = 0; i < 12; i++)
    begin
      k = xs();
      rd(k[2:0], k[6:3], 1'b1);
    end
    // Eight buffered words plus the one held at the output stage
    `CHK("buffer bound", 9, n_acc)
    hold_ready = 1'b0;
    for (int t = 0; t < 300 && exp_q.size() > 0; t++) @(posedge clock);
    repeat (4) @(posedge clock);
    `CHK("drained", 0, exp_q.size())
    `CHK("stream empty", 1'b0, beat_valid)
    conclude();
  end
endmodule
